// ---- rtl/jciu_top.v ----
/*
 * Instruction unit of a five-bit configuration TAP: instruction decode,
 * bypass / identification / 96-bit user paths, erase, program, verify
 * and auto-calibration of two nonvolatile configurations A and B.
 * Assumes tck, tms and tdi arrive asynchronously and tck is slow against
 * clk (at least four clk periods per tck phase). The nonvolatile cells
 * are modelled as registers inside this module.
 */
//
// Contract
// - instruction register is five bits, shifted in during Shift-IR
// - code 00000 acts as bypass, one-bit path only
// - code 11110 acts as bypass
// - code 11111 puts bypass bit between serial in and out
// - code 01101 selects 32-bit identification register, operation continues
// - after reset a data scan reads identification without loading instruction
// - code 00001 selects user register for Shift-DR, no interruption
// - user register 96 bits; B stores only capacitor settings
// - 00110/00111 program A/B on entering Run-Test/Idle, interrupting operation
// - programming only sets bits, never clears them
// - 00010/00011 erase A/B to zero, inputs cut, outputs at reference
// - 00100/00101 load A/B into user register without interruption
// - verify A yields correct data only while select bit is zero
// - 01100 arms calibration, starts in Run-Test/Idle, runs to completion
// - select, bypass, identification execute in Update-IR; others in idle
// - Capture-IR loads the identification instruction
// - tms high five clocks reaches Test-Logic-Reset, the power-on state
// - tdi and tms sampled on tck rise, tdo changes on tck fall
`timescale 1ns/1ps
`include "jciu_map.vh"
module jciu_top #(
    parameter CAL_CYCLES = (`JCIU_CAL_US * 1000) / `JCIU_CLK_NS
) (
    input wire clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo_q,
    output reg tdo_oe_n_q,
    output reg normal_run_q,
    output reg inputs_connected_q,
    output reg reference_output_level_q,
    output reg prog_busy_q,
    output reg erase_busy_q,
    output reg cal_busy_q,
    output reg config_sel_b_q,
    output reg [`JCIU_USER_W-1:0] active_config_q
);
    // =================================================================
    // path selection
    localparam [2:0] PATH_BYPASS = 3'h1;
    localparam [2:0] PATH_ID = 3'h2;
    localparam [2:0] PATH_USER = 3'h4;

    localparam [2:0] OP_IDLE = 3'h1;
    localparam [2:0] OP_RUN = 3'h2;
    localparam [2:0] OP_CAL = 3'h4;

    localparam [`JCIU_ID_W-1:0] ID_WORD = {`JCIU_ID_VERSION, `JCIU_ID_PART, `JCIU_ID_MAKER, 1'b1};
    localparam [`JCIU_USER_W-1:0] B_MASK = {{(`JCIU_USER_W-`JCIU_B_W){1'b0}}, {`JCIU_B_W{1'b1}}};

    function [2:0] path_of;
        input [`JCIU_IR_W-1:0] op;
        begin
            case (op)
                `JCIU_OP_IDCODE: path_of = PATH_ID;
                `JCIU_OP_SEL_USER: path_of = PATH_USER;
                default: path_of = PATH_BYPASS;
            endcase
        end
    endfunction

    function is_idle_op;
        input [`JCIU_IR_W-1:0] op;
        begin
            is_idle_op = (op == `JCIU_OP_ERASE_A) || (op == `JCIU_OP_ERASE_B) || (op == `JCIU_OP_PROG_A)
                || (op == `JCIU_OP_PROG_B) || (op == `JCIU_OP_VERIFY_A) || (op == `JCIU_OP_VERIFY_B)
                || (op == `JCIU_OP_CAL);
        end
    endfunction

    // =================================================================
    // pin sampling and TAP state
    wire tck_s;
    wire tck_rise;
    wire tck_fall;
    wire tms_s;
    wire tdi_s;
    wire [3:0] tap_q;

    jciu_sync u_sync_tck (
        .clk(clk),
        .rst(rst),
        .async_in(tck),
        .level(tck_s),
        .rise(tck_rise),
        .fall(tck_fall)
    );
    jciu_sync u_sync_tms (
        .clk(clk),
        .rst(rst),
        .async_in(tms),
        .level(tms_s),
        .rise(),
        .fall()
    );
    jciu_sync u_sync_tdi (
        .clk(clk),
        .rst(rst),
        .async_in(tdi),
        .level(tdi_s),
        .rise(),
        .fall()
    );

    jciu_tap_fsm u_fsm (
        .clk(clk),
        .rst(rst),
        .step(tck_rise),
        .tms(tms_s),
        .state_q(tap_q)
    );

    // =================================================================
    // registers
    reg [`JCIU_IR_W-1:0] ir_sh_q;
    reg [`JCIU_IR_W-1:0] ir_q;
    reg [2:0] path_q;
    reg bypass_q;
    reg [`JCIU_ID_W-1:0] id_sh_q;
    reg [`JCIU_USER_W-1:0] user_sh_q;
    reg [`JCIU_USER_W-1:0] nv_a_q;
    reg [`JCIU_USER_W-1:0] nv_b_q;
    reg [2:0] op_q;
    reg [31:0] cal_cnt_q;
    reg was_rti_q;

    wire in_rti = (tap_q == `JCIU_RTI);
    wire enter_rti = in_rti && !was_rti_q;
    wire serial_out;

    assign serial_out = (tap_q == `JCIU_SH_IR) ? ir_sh_q[0] :
                        (path_q == PATH_ID) ? id_sh_q[0] :
                        (path_q == PATH_USER) ? user_sh_q[0] : bypass_q;

    // =================================================================
    // instruction register and data paths
    always @(posedge clk) begin
        if (rst) begin
            ir_sh_q <= `JCIU_IR_CAPTURE;
            ir_q <= `JCIU_OP_IDCODE;
            path_q <= PATH_ID;
            bypass_q <= 1'b0;
            id_sh_q <= ID_WORD;
            user_sh_q <= {`JCIU_USER_W{1'b0}};
        end else if (tck_rise) begin
            case (tap_q)
                `JCIU_TLR: begin
                    ir_q <= `JCIU_OP_IDCODE;
                    path_q <= PATH_ID;
                end
                `JCIU_CAP_IR: ir_sh_q <= `JCIU_OP_IDCODE;
                `JCIU_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[`JCIU_IR_W-1:1]};
                `JCIU_UPD_IR: begin
                    ir_q <= ir_sh_q;
                    if (!is_idle_op(ir_sh_q)) begin
                        path_q <= path_of(ir_sh_q);
                    end else begin
                        path_q <= PATH_BYPASS;
                    end
                end
                `JCIU_CAP_DR: begin
                    bypass_q <= 1'b0;
                    id_sh_q <= ID_WORD;
                end
                `JCIU_SH_DR: begin
                    bypass_q <= tdi_s;
                    id_sh_q <= {tdi_s, id_sh_q[`JCIU_ID_W-1:1]};
                    user_sh_q <= {tdi_s, user_sh_q[`JCIU_USER_W-1:1]};
                end
                default: ;
            endcase
        end else if (op_q == OP_IDLE && enter_rti && ir_q == `JCIU_OP_VERIFY_A) begin
            // select bit set scrambles the readback, as the cells do
            user_sh_q <= nv_a_q[`JCIU_AB_SEL_BIT] ? ~nv_a_q : nv_a_q;
        end else if (op_q == OP_IDLE && enter_rti && ir_q == `JCIU_OP_VERIFY_B) begin
            user_sh_q <= nv_b_q & B_MASK;
        end
    end

    // =================================================================
    // idle-triggered operations
    always @(posedge clk) begin
        if (rst) begin
            op_q <= OP_IDLE;
            cal_cnt_q <= 32'h0000_0000;
            was_rti_q <= 1'b0;
            nv_a_q <= {`JCIU_USER_W{1'b0}};
            nv_b_q <= {`JCIU_USER_W{1'b0}};
            prog_busy_q <= 1'b0;
            erase_busy_q <= 1'b0;
            cal_busy_q <= 1'b0;
        end else begin
            was_rti_q <= in_rti;
            case (op_q)
                OP_IDLE: begin
                    if (enter_rti) begin
                        case (ir_q)
                            `JCIU_OP_PROG_A, `JCIU_OP_PROG_B: begin
                                op_q <= OP_RUN;
                                prog_busy_q <= 1'b1;
                            end
                            `JCIU_OP_ERASE_A, `JCIU_OP_ERASE_B: begin
                                op_q <= OP_RUN;
                                erase_busy_q <= 1'b1;
                            end
                            `JCIU_OP_CAL: begin
                                op_q <= OP_CAL;
                                cal_busy_q <= 1'b1;
                                cal_cnt_q <= CAL_CYCLES;
                            end
                            default: ;
                        endcase
                    end
                end
                OP_RUN: begin
                    // the cells act for as long as idle is held; the programmer owns the time
                    if (ir_q == `JCIU_OP_PROG_A) begin
                        nv_a_q <= nv_a_q | user_sh_q;
                    end else if (ir_q == `JCIU_OP_PROG_B) begin
                        nv_b_q <= nv_b_q | (user_sh_q & B_MASK);
                    end else if (ir_q == `JCIU_OP_ERASE_A) begin
                        nv_a_q <= {`JCIU_USER_W{1'b0}};
                    end else begin
                        nv_b_q <= {`JCIU_USER_W{1'b0}};
                    end
                    if (!in_rti) begin
                        op_q <= OP_IDLE;
                        prog_busy_q <= 1'b0;
                        erase_busy_q <= 1'b0;
                    end
                end
                OP_CAL: begin
                    // independent of TAP activity once started
                    if (cal_cnt_q <= 32'h0000_0001) begin
                        op_q <= OP_IDLE;
                        cal_busy_q <= 1'b0;
                    end
                    cal_cnt_q <= cal_cnt_q - 32'h0000_0001;
                end
                default: op_q <= OP_IDLE;
            endcase
        end
    end

    // =================================================================
    // outputs
    always @(posedge clk) begin
        if (rst) begin
            tdo_q <= 1'b0;
            tdo_oe_n_q <= 1'b1;
            normal_run_q <= 1'b1;
            inputs_connected_q <= 1'b1;
            reference_output_level_q <= 1'b0;
            config_sel_b_q <= 1'b0;
            active_config_q <= {`JCIU_USER_W{1'b0}};
        end else begin
            if (tck_fall) begin
                tdo_q <= serial_out;
                tdo_oe_n_q <= !((tap_q == `JCIU_SH_IR) || (tap_q == `JCIU_SH_DR));
            end
            normal_run_q <= (op_q == OP_IDLE);
            inputs_connected_q <= !erase_busy_q;
            reference_output_level_q <= erase_busy_q || cal_busy_q;
            config_sel_b_q <= nv_a_q[`JCIU_AB_SEL_BIT];
            active_config_q <= nv_a_q[`JCIU_AB_SEL_BIT] ? ((nv_a_q & ~B_MASK) | nv_b_q) : nv_a_q;
        end
    end
endmodule

// ---- rtl/jciu_map.vh ----
/*
 * Constants for the configuration instruction unit: instruction codes,
 * register lengths, TAP state codes and identification fields.
 * Assumes inclusion by the Verilog design files and by the SystemVerilog checker and bench.
 */
`ifndef JCIU_MAP_VH
`define JCIU_MAP_VH

// =====================================================================
// instruction register
`define JCIU_IR_W 5
`define JCIU_OP_EXTEST 5'h00
`define JCIU_OP_SEL_USER 5'h01
`define JCIU_OP_ERASE_A 5'h02
`define JCIU_OP_ERASE_B 5'h03
`define JCIU_OP_VERIFY_A 5'h04
`define JCIU_OP_VERIFY_B 5'h05
`define JCIU_OP_PROG_A 5'h06
`define JCIU_OP_PROG_B 5'h07
`define JCIU_OP_CAL 5'h0C
`define JCIU_OP_IDCODE 5'h0D
`define JCIU_OP_SAMPLE 5'h1E
`define JCIU_OP_BYPASS 5'h1F
// reset value of the instruction shift register, low bits 01 per the standard
`define JCIU_IR_CAPTURE 5'h01

// =====================================================================
// data registers
`define JCIU_ID_W 32
`define JCIU_USER_W 96
// configuration B only holds capacitor settings, in the low bits
`define JCIU_B_W 64
// position of the A/B select bit inside the stored A image
`define JCIU_AB_SEL_BIT 95

// =====================================================================
// TAP state codes, sixteen states
`define JCIU_TLR 4'hF
`define JCIU_RTI 4'hC
`define JCIU_SEL_DR 4'h7
`define JCIU_CAP_DR 4'h6
`define JCIU_SH_DR 4'h2
`define JCIU_EX1_DR 4'h1
`define JCIU_PAU_DR 4'h3
`define JCIU_EX2_DR 4'h0
`define JCIU_UPD_DR 4'h5
`define JCIU_SEL_IR 4'h4
`define JCIU_CAP_IR 4'hE
`define JCIU_SH_IR 4'hA
`define JCIU_EX1_IR 4'h9
`define JCIU_PAU_IR 4'hB
`define JCIU_EX2_IR 4'h8
`define JCIU_UPD_IR 4'hD

// =====================================================================
// identification word, values arbitrary
`define JCIU_ID_VERSION 4'h1
`define JCIU_ID_PART 16'h0A5C
`define JCIU_ID_MAKER 11'h155

// =====================================================================
// timing at 100 MHz
`define JCIU_CLK_NS 10
`define JCIU_CAL_US 20000

`endif

// ---- rtl/jciu_sync.v ----
/*
 * Two-flop synchroniser with rise and fall detection on the synchronised
 * level. Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module jciu_sync (
    input wire clk,
    input wire rst,
    input wire async_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule

// ---- rtl/jciu_tap_fsm.v ----
/*
 * Sixteen-state TAP controller advanced by one step per detected TCK rise.
 * Assumes tms is already synchronised and valid when step is high.
 */
`timescale 1ns/1ps
`include "jciu_map.vh"
module jciu_tap_fsm (
    input wire clk,
    input wire rst,
    input wire step,
    input wire tms,
    output reg [3:0] state_q
);
    reg [3:0] state_d;

    always @* begin
        case (state_q)
            `JCIU_TLR: state_d = tms ? `JCIU_TLR : `JCIU_RTI;
            `JCIU_RTI: state_d = tms ? `JCIU_SEL_DR : `JCIU_RTI;
            `JCIU_SEL_DR: state_d = tms ? `JCIU_SEL_IR : `JCIU_CAP_DR;
            `JCIU_CAP_DR: state_d = tms ? `JCIU_EX1_DR : `JCIU_SH_DR;
            `JCIU_SH_DR: state_d = tms ? `JCIU_EX1_DR : `JCIU_SH_DR;
            `JCIU_EX1_DR: state_d = tms ? `JCIU_UPD_DR : `JCIU_PAU_DR;
            `JCIU_PAU_DR: state_d = tms ? `JCIU_EX2_DR : `JCIU_PAU_DR;
            `JCIU_EX2_DR: state_d = tms ? `JCIU_UPD_DR : `JCIU_SH_DR;
            `JCIU_UPD_DR: state_d = tms ? `JCIU_SEL_DR : `JCIU_RTI;
            `JCIU_SEL_IR: state_d = tms ? `JCIU_TLR : `JCIU_CAP_IR;
            `JCIU_CAP_IR: state_d = tms ? `JCIU_EX1_IR : `JCIU_SH_IR;
            `JCIU_SH_IR: state_d = tms ? `JCIU_EX1_IR : `JCIU_SH_IR;
            `JCIU_EX1_IR: state_d = tms ? `JCIU_UPD_IR : `JCIU_PAU_IR;
            `JCIU_PAU_IR: state_d = tms ? `JCIU_EX2_IR : `JCIU_PAU_IR;
            `JCIU_EX2_IR: state_d = tms ? `JCIU_UPD_IR : `JCIU_SH_IR;
            `JCIU_UPD_IR: state_d = tms ? `JCIU_SEL_DR : `JCIU_RTI;
            default: state_d = `JCIU_TLR;
        endcase
    end

    // tms high walks every state to reset within five steps
    always @(posedge clk) begin
        if (rst) begin
            state_q <= `JCIU_TLR;
        end else if (step) begin
            state_q <= state_d;
        end
    end
endmodule

// ---- verif/jciu_top_checker.sv ----
/* Concurrent checks on the ports of the configuration instruction unit.
   Assumes one clk domain, rst synchronous active high, and that tck is
   slow against clk. */
`timescale 1ns/1ps
`include "jciu_map.vh"
module jciu_top_checker #(
    parameter CAL_CYCLES = 50
) (
    input wire clk,
    input wire rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire tdo_q,
    input wire tdo_oe_n_q,
    input wire normal_run_q,
    input wire inputs_connected_q,
    input wire reference_output_level_q,
    input wire prog_busy_q,
    input wire erase_busy_q,
    input wire cal_busy_q,
    input wire config_sel_b_q,
    input wire [`JCIU_USER_W-1:0] active_config_q
);
    // ==========================================
    // helper: length of the current calibration
    int cal_cnt_q;
    always @(posedge clk) begin
        if (rst || !cal_busy_q)
            cal_cnt_q <= 0;
        else
            cal_cnt_q <= cal_cnt_q + 1;
    end

    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire any_busy = prog_busy_q | erase_busy_q | cal_busy_q;
    sequence op_starts;
        $rose(prog_busy_q) || $rose(erase_busy_q);
    endsequence
    sequence run_halted;
        !normal_run_q ##1 !normal_run_q;
    endsequence
    sequence quiet_two;
        !any_busy ##1 !any_busy;
    endsequence

    chk_op_halts_run: assert property (op_starts |=> run_halted)
        else $error("program or erase left normal run on");
    chk_erase_isolates: assert property ($rose(erase_busy_q) |=> !inputs_connected_q && reference_output_level_q)
        else $error("erase did not isolate inputs and outputs");
    chk_one_op_only: assert property ($onehot0({prog_busy_q, erase_busy_q, cal_busy_q}))
        else $error("more than one operation running");
    chk_op_ends_tck: assert property ($fell(prog_busy_q) || $fell(erase_busy_q) |-> $past(tck, 2))
        else $error("program or erase ended without tap movement");
    chk_run_resumes: assert property ($fell(prog_busy_q) || $fell(erase_busy_q) |=> normal_run_q && inputs_connected_q)
        else $error("normal run not restored after operation");
    chk_cal_length: assert property ($fell(cal_busy_q) |-> cal_cnt_q >= CAL_CYCLES - 1 && cal_cnt_q <= CAL_CYCLES + 1)
        else $error("calibration length wrong");
    chk_cal_to_ref: assert property ($rose(cal_busy_q) |=> (reference_output_level_q && !normal_run_q)[*3])
        else $error("calibration did not force reference level");
    chk_quiet_idle: assert property (quiet_two |-> normal_run_q && inputs_connected_q && !reference_output_level_q)
        else $error("operation disturbed while idle");
    chk_tdo_on_fall: assert property ($changed(tdo_q) || $changed(tdo_oe_n_q) |-> !tck)
        else $error("serial output moved while tck high");
    chk_sel_mirrors: assert property (config_sel_b_q == active_config_q[`JCIU_AB_SEL_BIT])
        else $error("select bit disagrees with active image");
endmodule

bind jciu_top jciu_top_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_n_q(tdo_oe_n_q),
    .normal_run_q(normal_run_q), .inputs_connected_q(inputs_connected_q),
    .reference_output_level_q(reference_output_level_q), .prog_busy_q(prog_busy_q),
    .erase_busy_q(erase_busy_q), .cal_busy_q(cal_busy_q), .config_sel_b_q(config_sel_b_q),
    .active_config_q(active_config_q)
);

// ---- verif/jciu_prog_model.sv ----
/* Behavioural serial programmer driving the TAP pins.
   Assumes the caller starts ir and dr scans in Run-Test/Idle; tck stands
   low between steps, tms and tdi rest high as with pull-ups. */
`timescale 1ns/1ps
module jciu_prog_model (
    input wire clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end

    // ==========================================
    // one tck period, eight clk high and at least eight clk low
    task automatic step(input logic m, input logic di, output logic q);
        @(negedge clk);
        tms = m;
        tdi = di;
        repeat (8) @(negedge clk);
        q = tdo;
        tck = 1'h1;
        repeat (8) @(negedge clk);
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    endtask
    // tms walk, lsb first
    task automatic go(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'h1, q);
    endtask
    // leaves the tap in reset, tck still
    task automatic reset5();
        go(8'h1F, 5);
    endtask
    task automatic shift(input logic [95:0] din, input int n, output logic [95:0] dout);
        logic q;
        dout = 96'h0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        go(8'h01, 2);
    endtask
    task automatic ir(input logic [4:0] code);
        logic [95:0] d;
        go(8'h03, 4);
        shift({91'h0, code}, 5, d);
    endtask
    task automatic dr(input logic [95:0] din, input int n, output logic [95:0] dout);
        go(8'h01, 3);
        shift(din, n, dout);
    endtask
endmodule

// ---- verif/jciu_top_test.sv ----
/* Self-checking bench for the configuration instruction unit.
   Assumes the programmer model in jciu_prog_model and a short
   calibration count set here. */
`timescale 1ns/1ps
`include "jciu_map.vh"
module jciu_top_test;
    logic clk;
    logic rst;
    wire tck, tms, tdi, tdo_q, tdo_oe_n_q, normal_run_q, inputs_connected_q, reference_output_level_q;
    wire prog_busy_q, erase_busy_q, cal_busy_q, config_sel_b_q;
    wire [`JCIU_USER_W-1:0] active_config_q;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [95:0] d;
    logic q;
    localparam logic [95:0] ID = {64'h0, `JCIU_ID_VERSION, `JCIU_ID_PART, `JCIU_ID_MAKER, 1'h1};
    localparam logic [95:0] D1 = 96'h0123_4567_89AB_CDEF_0F0F_1234;
    localparam logic [95:0] D2 = 96'h0800_0000_0000_0000_0000_00C3;
    localparam logic [95:0] D3 = 96'hFFFF_FFFF_A5A5_5A5A_3C3C_C3C3;
    localparam logic [95:0] D12 = D1 | D2;

    jciu_top #(.CAL_CYCLES(50)) dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_n_q(tdo_oe_n_q),
        .normal_run_q(normal_run_q), .inputs_connected_q(inputs_connected_q),
        .reference_output_level_q(reference_output_level_q), .prog_busy_q(prog_busy_q),
        .erase_busy_q(erase_busy_q), .cal_busy_q(cal_busy_q), .config_sel_b_q(config_sel_b_q),
        .active_config_q(active_config_q)
    );
    jciu_prog_model prog (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_q));

    // ==========================================
    // checking and closing
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({95'h0, got}, {95'h0, exp});
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================
    // scan helpers
    task automatic load_user(input logic [95:0] v);
        prog.ir(`JCIU_OP_SEL_USER);
        prog.dr(v, 96, d);
    endtask
    task automatic read_back(input logic [4:0] ver, output logic [95:0] v);
        prog.ir(ver);
        prog.ir(`JCIU_OP_SEL_USER);
        prog.dr(96'h0, 96, v);
    endtask
    // idle dwell stands in for the programming time
    task automatic run_op(input logic [4:0] op);
        prog.ir(op);
        repeat (30) @(negedge clk);
    endtask

    // ==========================================
    // scenarios
    task automatic t_ident();
        prog.go(8'h00, 1);
        prog.dr(96'h0, 32, d);
        chk(d, ID);
        chk1(normal_run_q, 1'h1);
        chk1(tdo_oe_n_q, 1'h1);
        prog.ir(`JCIU_OP_BYPASS);
        prog.reset5();
        prog.go(8'h00, 1);
        prog.dr(96'h0, 32, d);
        chk(d, ID);
        prog.ir(`JCIU_OP_IDCODE);
        prog.dr(96'hFFFF_FFFF, 32, d);
        chk(d, ID);
        $display("test ident done");
    endtask

    task automatic t_bypass();
        logic [4:0] codes [5] = '{`JCIU_OP_EXTEST, `JCIU_OP_SAMPLE, `JCIU_OP_BYPASS, 5'h08, 5'h15};
        foreach (codes[i]) begin
            prog.ir(codes[i]);
            prog.dr(96'hB5, 8, d);
            chk(d, 96'h6A);
            chk1(prog_busy_q | erase_busy_q | cal_busy_q, 1'h0);
        end
        $display("test bypass done");
    endtask

    task automatic t_memory();
        logic [95:0] v;
        run_op(`JCIU_OP_ERASE_A);
        chk1(erase_busy_q, 1'h1);
        chk1(inputs_connected_q, 1'h0);
        chk1(reference_output_level_q, 1'h1);
        read_back(`JCIU_OP_VERIFY_A, v);
        chk(v, 96'h0);
        chk1(erase_busy_q, 1'h0);
        load_user(D1);
        run_op(`JCIU_OP_PROG_A);
        chk1(prog_busy_q, 1'h1);
        chk1(normal_run_q, 1'h0);
        read_back(`JCIU_OP_VERIFY_A, v);
        chk(v, D1);
        chk(active_config_q, D1);
        load_user(D2);
        run_op(`JCIU_OP_PROG_A);
        read_back(`JCIU_OP_VERIFY_A, v);
        chk(v, D12);
        run_op(`JCIU_OP_ERASE_B);
        load_user(D3);
        run_op(`JCIU_OP_PROG_B);
        read_back(`JCIU_OP_VERIFY_B, v);
        chk(v, {32'h0, D3[63:0]});
        load_user(96'h8000_0000_0000_0000_0000_0000);
        run_op(`JCIU_OP_PROG_A);
        prog.ir(`JCIU_OP_BYPASS);
        chk1(config_sel_b_q, 1'h1);
        chk(active_config_q, {1'h1, D12[94:64], D3[63:0]});
        // select bit set: readback of A comes back scrambled
        read_back(`JCIU_OP_VERIFY_A, v);
        chk(v, ~{1'h1, D12[94:0]});
        $display("test memory done");
    endtask

    task automatic t_cal();
        prog.ir(`JCIU_OP_CAL);
        chk1(cal_busy_q, 1'h1);
        prog.step(1'h1, 1'h1, q);
        chk1(cal_busy_q, 1'h1);
        chk1(reference_output_level_q, 1'h1);
        prog.reset5();
        chk1(cal_busy_q, 1'h0);
        chk1(normal_run_q, 1'h1);
        $display("test calibration done");
    endtask

    // ==========================================
    // clock, reset, sequence, hang guard
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'h1;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        t_ident();
        t_bypass();
        t_memory();
        t_cal();
        wrap_up();
    end
    // expected run is near 24300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end
endmodule
